// >>> verilog/calib_crc_regs.sv
// AHB-Lite register slice: calibration read-back and signature check
//
// Notes on behaviour
// - Upper status field chosen by status select
// - Select one: phase bits 20:15, rest zero
// - Select zero: signed filter value in low field
// - Low field: phase, DAC byte, slow value
// - Read returns previous snapshot, captures fresh one
// - Whole word from one snapshot
// - Bit zero flags accelerated calibration running
// - Flag low when done or divider reset
// - Expected signature register, read/write, resets zero
// - Computed signature readable separately
// - Mismatch sets reload or fail per mode
// - Manual trigger starts check unless busy, self-clears
//
// The AHB-Lite register port was left to the implementer.
module calib_crc_regs
(
   // AHB-Lite slave
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic [31:0]                   hrdata,
   // Calibrator status
   input  wire logic [16:0]              ring_osc_state_count,
   input  wire logic [20:0]              ring_osc_phase,
   input  wire logic [16:0]              ring_osc_captured,
   input  wire logic [16:0]              ring_osc_analog,
   input  wire logic [14:0]              lpf_value,
   input  wire logic [7:0]               dac_control,
   input  wire logic [14:0]              slow_calib_value,
   input  wire logic                     accel_calib_running,
   input  wire logic                     fod_in_reset,
   // Configuration store and automatic check
   input  wire logic [31:0]              cfg_word,
   input  wire logic                     auto_check_req,
   output logic [calib_crc_pkg::IDX_W-1:0] cfg_index,
   output logic                          check_busy,
   // Interrupt
   output logic                          irq
);

   crc_link_if link ();

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [31:0]                          sig_exp;
   logic [31:0]                          calib_snap;
   logic                                 fast_flag;
   logic [1:0]                           status_sel;
   logic                                 err_mode;
   logic [calib_crc_pkg::EVT_W-1:0]      event_sts;
   logic [calib_crc_pkg::EVT_W-1:0]      event_mask;
   logic                                 start_q;
   logic                                 wr_pend;
   logic [7:0]                           wr_addr;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire        addr_phase  = hsel & htrans[1] & hready;
   wire        rd_take     = addr_phase & ~hwrite;
   wire        wr_take     = addr_phase & hwrite;
   wire [7:0]  rd_off      = {haddr[7:2], 2'b00};
   wire        in_range    = (haddr[31:8] == 24'h00_0000);
   wire        rd_calib    = rd_take & in_range &
                             (rd_off == calib_crc_pkg::OFF_CALIB_STS);
   wire        wr_sig      = wr_pend &
                             (wr_addr == calib_crc_pkg::OFF_SIG_EXP);
   wire        wr_ctl      = wr_pend &
                             (wr_addr == calib_crc_pkg::OFF_CONTROL);
   wire        wr_evt      = wr_pend &
                             (wr_addr == calib_crc_pkg::OFF_EVENT);
   wire        wr_mask     = wr_pend &
                             (wr_addr == calib_crc_pkg::OFF_EVENT_MASK);

   ////////////////////////////////////////////////////////////////////////
   // Fresh calibration status
   logic [16:0] upper_sel;
   logic [14:0] lower_sel;

   always_comb
   begin
      upper_sel = '0;
      lower_sel = '0;
      case (calib_crc_pkg::status_sel_t'(status_sel))
         calib_crc_pkg::SEL_LPF:
         begin
            upper_sel = ring_osc_state_count;
            lower_sel = lpf_value;
         end
         calib_crc_pkg::SEL_PHASE:
         begin
            upper_sel = {11'h000, ring_osc_phase[20:15]};
            lower_sel = ring_osc_phase[14:0];
         end
         calib_crc_pkg::SEL_CAPTURED:
         begin
            upper_sel = ring_osc_captured;
            lower_sel = {7'h00, dac_control};
         end
         calib_crc_pkg::SEL_ANALOG:
         begin
            upper_sel = ring_osc_analog;
            lower_sel = slow_calib_value;
         end
         default:
         begin
            upper_sel = '0;
            lower_sel = '0;
         end
      endcase
   end

   wire [31:0] calib_fresh = {upper_sel, lower_sel};

   ////////////////////////////////////////////////////////////////////////
   // Read data selection
   wire [31:0] ctl_word  = {28'h000_0000, 1'b0, err_mode, status_sel};
   wire [31:0] evt_word  = {29'h0000_0000, event_sts};
   wire [31:0] mask_word = {29'h0000_0000, event_mask};
   wire [31:0] fast_word = {31'h0000_0000, fast_flag};
   logic [31:0] rd_mux;

   always_comb
   begin
      rd_mux = '0;
      if (in_range)
      begin
         case (rd_off)
            calib_crc_pkg::OFF_SIG_EXP:    rd_mux = sig_exp;
            calib_crc_pkg::OFF_CALIB_STS:  rd_mux = calib_snap;
            calib_crc_pkg::OFF_FAST_STS:   rd_mux = fast_word;
            calib_crc_pkg::OFF_SIG_CALC:   rd_mux = link.result;
            calib_crc_pkg::OFF_CONTROL:    rd_mux = ctl_word;
            calib_crc_pkg::OFF_EVENT:      rd_mux = evt_word;
            calib_crc_pkg::OFF_EVENT_MASK: rd_mux = mask_word;
            default:                       rd_mux = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus response and read data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
         hrdata    <= calib_crc_pkg::RST_WORD;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (rd_take)
         begin
            hrdata <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write address capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= wr_take & in_range;
         wr_addr <= {haddr[7:2], 2'b00};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status snapshot, one word wide so all bytes agree
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         calib_snap <= calib_crc_pkg::RST_WORD;
      end
      else if (rd_calib)
      begin
         calib_snap <= calib_fresh;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Accelerated calibration flag
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fast_flag <= 1'b0;
      end
      else
      begin
         fast_flag <= accel_calib_running & ~fod_in_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Expected signature and control
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sig_exp    <= calib_crc_pkg::RST_SIG_EXP;
         status_sel <= calib_crc_pkg::RST_SEL;
         err_mode   <= 1'b0;
         event_mask <= calib_crc_pkg::RST_EVT;
      end
      else
      begin
         if (wr_sig)
         begin
            sig_exp <= hwdata;
         end
         if (wr_ctl)
         begin
            status_sel <= hwdata[calib_crc_pkg::CTL_SEL_LSB +: 2];
            err_mode   <= hwdata[calib_crc_pkg::CTL_ERR_MODE];
         end
         if (wr_mask)
         begin
            event_mask <= hwdata[calib_crc_pkg::EVT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Check start: manual trigger is a write-only pulse
   // Requests during a pass are dropped
   wire manual_trig = wr_ctl & hwdata[calib_crc_pkg::CTL_TRIG];
   wire next_start  = (manual_trig | auto_check_req) &
                      ~link.busy & ~start_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         start_q <= 1'b0;
      end
      else
      begin
         start_q <= next_start;
      end
   end

   assign link.start = start_q;
   assign link.word  = cfg_word;

   ////////////////////////////////////////////////////////////////////////
   // Events: hardware set wins over write-one clear
   wire mismatch = link.done & (link.result != sig_exp);
   logic [calib_crc_pkg::EVT_W-1:0] evt_set;

   always_comb
   begin
      evt_set = '0;
      evt_set[calib_crc_pkg::EVT_RELOAD] = mismatch & ~err_mode;
      evt_set[calib_crc_pkg::EVT_FAIL]   = mismatch & err_mode;
      evt_set[calib_crc_pkg::EVT_DONE]   = link.done;
   end

   wire [calib_crc_pkg::EVT_W-1:0] evt_clr =
      wr_evt ? hwdata[calib_crc_pkg::EVT_W-1:0] : '0;

   genvar g;
   generate
      for (g = 0; g < calib_crc_pkg::EVT_W; g++)
      begin : g_evt
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               event_sts[g] <= 1'b0;
            end
            else
            begin
               event_sts[g] <= evt_set[g] | (event_sts[g] & ~evt_clr[g]);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   // Interrupt from registered status only
   wire next_irq = |(event_sts & event_mask);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= next_irq;
      end
   end

   // Busy from start pulse to end of pass
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         check_busy <= 1'b0;
      end
      else
      begin
         check_busy <= link.busy | start_q;
      end
   end

   assign cfg_index = link.index;

   ////////////////////////////////////////////////////////////////////////
   // Signature engine
   config_crc_engine u_crc
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .link    (link.engine)
   );

endmodule

// >>> verilog/calib_crc_pkg.sv
// Constants, register map and types for the calibration and signature block
package calib_crc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFF_SIG_EXP     = 8'h00;
   localparam logic [7:0] OFF_CALIB_STS   = 8'h04;
   localparam logic [7:0] OFF_FAST_STS    = 8'h08;
   localparam logic [7:0] OFF_SIG_CALC    = 8'h0C;
   localparam logic [7:0] OFF_CONTROL     = 8'h10;
   localparam logic [7:0] OFF_EVENT       = 8'h14;
   localparam logic [7:0] OFF_EVENT_MASK  = 8'h18;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTL_SEL_LSB    = 0;
   localparam int CTL_ERR_MODE   = 2;
   localparam int CTL_TRIG       = 3;
   localparam int EVT_RELOAD     = 0;
   localparam int EVT_FAIL       = 1;
   localparam int EVT_DONE       = 2;
   localparam int EVT_W          = 3;
   localparam int UPPER_LSB      = 15;
   localparam int UPPER_W        = 17;
   localparam int LOWER_W        = 15;
   localparam int PHASE_W        = 21;
   localparam int DAC_W          = 8;
   localparam int FAST_BIT       = 0;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [31:0] RST_SIG_EXP  = 32'h0000_0000;
   localparam logic [31:0] RST_WORD     = 32'h0000_0000;
   localparam logic [1:0]  RST_SEL      = 2'h0;
   localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // Status select codes
   typedef enum logic [1:0]
   {
      SEL_LPF      = 2'h0,
      SEL_PHASE    = 2'h1,
      SEL_CAPTURED = 2'h2,
      SEL_ANALOG   = 2'h3
   } status_sel_t;

   ////////////////////////////////////////////////////////////////////////
   // Signature engine
   localparam int          CFG_WORDS = 16;
   localparam int          IDX_W     = 4;
   localparam logic [31:0] CRC_INIT  = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY  = 32'hEDB8_8320;
   localparam logic [31:0] CRC_XOR   = 32'hFFFF_FFFF;
   localparam logic [IDX_W-1:0] IDX_LAST = 4'hF;

endpackage

// >>> verilog/crc_link_if.sv
// Handshake between register slice and signature engine
interface crc_link_if;
   logic                               start;
   logic                               busy;
   logic                               done;
   logic [31:0]                        word;
   logic [calib_crc_pkg::IDX_W-1:0]    index;
   logic [31:0]                        result;

   modport engine (input start, input word,
                   output busy, output done, output index, output result);
   modport ctrl   (output start, output word,
                   input busy, input done, input index, input result);
endinterface

// >>> verilog/config_crc_engine.sv
// CRC-32 pass over the configuration words, one word a cycle
module config_crc_engine
(
   // Clock and reset
   input  wire logic   hclk,
   input  wire logic   hresetn,
   // Link to register slice
   crc_link_if.engine  link
);

   typedef enum logic [0:0]
   {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } crc_state_t;

   crc_state_t    state;
   logic [31:0]   crc;
   wire  [31:0]   next_crc;
   wire           last_word;

   ////////////////////////////////////////////////////////////////////////
   // Bit-serial reflected CRC-32 over one word, low bit first
   function automatic logic [31:0] crc_word(input logic [31:0] c,
                                            input logic [31:0] w);
      logic [31:0] r;
      r = c ^ w;
      for (int i = 0; i < 32; i++)
      begin
         r = r[0] ? ((r >> 1) ^ calib_crc_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   assign next_crc  = crc_word(crc, link.word);
   assign last_word = (link.index == calib_crc_pkg::IDX_LAST);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state       <= ST_IDLE;
         crc         <= calib_crc_pkg::CRC_INIT;
         link.index  <= '0;
         link.busy   <= 1'b0;
         link.done   <= 1'b0;
         link.result <= calib_crc_pkg::RST_WORD;
      end
      else
      begin
         link.done <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (link.start)
               begin
                  state      <= ST_RUN;
                  crc        <= calib_crc_pkg::CRC_INIT;
                  link.index <= '0;
                  link.busy  <= 1'b1;
               end
            end
            ST_RUN:
            begin
               crc <= next_crc;
               if (last_word)
               begin
                  state       <= ST_IDLE;
                  link.busy   <= 1'b0;
                  link.done   <= 1'b1;
                  link.result <= next_crc ^ calib_crc_pkg::CRC_XOR;
               end
               else
               begin
                  link.index <= link.index + 1'b1;
               end
            end
            default:
            begin
               state     <= ST_IDLE;
               link.busy <= 1'b0;
            end
         endcase
      end
   end

endmodule

// >>> verification/calib_crc_regs_assertions.sv
// Concurrent checks on the register slice ports
module calib_crc_regs_assertions
(
   // Bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Status and check
   input wire logic        accel_calib_running,
   input wire logic        fod_in_reset,
   input wire logic        auto_check_req,
   input wire logic [calib_crc_pkg::IDX_W-1:0] cfg_index,
   input wire logic        check_busy,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   //////////////////////////////////////////////////////////////////////
   // Helpers
   wire logic req = hsel && htrans[1] && hready;
   wire logic rd  = req && !hwrite;
   wire logic lo  = (haddr[31:8] == 24'h0);
   wire logic ev_wr = req && hwrite && lo &&
      (haddr[7:0] == calib_crc_pkg::OFF_EVENT ||
       haddr[7:0] == calib_crc_pkg::OFF_EVENT_MASK);
   wire logic fast_on = accel_calib_running && !fod_in_reset;
   logic      ctl_dp;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctl_dp <= 1'b0;
      else
         ctl_dp <= req && hwrite && lo &&
                   haddr[7:0] == calib_crc_pkg::OFF_CONTROL;
   end

   //////////////////////////////////////////////////////////////////////
   // Assertions
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   a_ready_high: assert property ($past(hresetn) |-> hreadyout)
      else $error("hreadyout low");
   a_rdata_hold: assert property (!rd |=> $stable(hrdata))
      else $error("hrdata moved without read");
   a_fast_read: assert property (rd && lo && $past(hresetn) &&
      haddr[7:0] == calib_crc_pkg::OFF_FAST_STS
      |=> hrdata == {31'h0, $past(fast_on, 2)})
      else $error("fast flag wrong");
   a_trig_start: assert property (ctl_dp && !check_busy &&
      hwdata[calib_crc_pkg::CTL_TRIG] |-> ##[1:3] check_busy)
      else $error("manual trigger ignored");
   a_auto_start: assert property (auto_check_req && !check_busy
      |-> ##[1:3] check_busy)
      else $error("auto request ignored");
   a_busy_min: assert property ($rose(check_busy)
      |-> check_busy[*8])
      else $error("pass ended early");
   a_busy_max: assert property ($rose(check_busy)
      |-> ##[15:20] !check_busy)
      else $error("pass too long");
   a_index_first: assert property ($rose(check_busy)
      |-> ##[0:1] cfg_index == 4'h0 ##1 cfg_index == 4'h1)
      else $error("index order wrong");
   a_irq_fall: assert property ($fell(irq)
      |-> $past(ev_wr, 2) || $past(ev_wr, 3))
      else $error("irq fell without write");

   // Covers
   c_check_done: cover property ($fell(check_busy));
   c_irq_up: cover property ($rose(irq));
   c_fast_rd: cover property (rd && haddr[7:0] == 8'h08);
endmodule

// >>> verification/calib_crc_regs_test.sv
// Self-checking bench for the calibration and signature register slice
bind calib_crc_regs calib_crc_regs_assertions u_calib_crc_regs_assertions
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .accel_calib_running(accel_calib_running),
   .fod_in_reset(fod_in_reset), .auto_check_req(auto_check_req),
   .cfg_index(cfg_index), .check_busy(check_busy), .irq(irq)
);

module calib_crc_regs_test;
   timeunit 1ns;
   timeprecision 1ps;

   // Bus
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   // Status and check
   logic [16:0] ring_osc_state_count = 17'h0;
   logic [20:0] ring_osc_phase       = 21'h0;
   logic [16:0] ring_osc_captured    = 17'h0;
   logic [16:0] ring_osc_analog      = 17'h0;
   logic [14:0] lpf_value            = 15'h0;
   logic [7:0]  dac_control          = 8'h0;
   logic [14:0] slow_calib_value     = 15'h0;
   logic        accel_calib_running  = 1'b0;
   logic        fod_in_reset         = 1'b0;
   logic        auto_check_req       = 1'b0;
   logic [31:0] cfg_word;
   logic [calib_crc_pkg::IDX_W-1:0] cfg_index;
   logic        check_busy;
   logic        irq;
   // Bench state
   int          num_errors = 0;
   int          n_tests    = 0;
   logic [31:0] snap       = 32'h0;
   logic [31:0] rdv;

   always #5 hclk = ~hclk;

   function automatic logic [31:0] cfg_at(input logic [3:0] i);
      return {8{i}} ^ 32'h5A3C_96E1;
   endfunction

   assign cfg_word = cfg_at(cfg_index);

   calib_crc_regs u_calib_crc_regs
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .ring_osc_state_count(ring_osc_state_count),
      .ring_osc_phase(ring_osc_phase),
      .ring_osc_captured(ring_osc_captured),
      .ring_osc_analog(ring_osc_analog), .lpf_value(lpf_value),
      .dac_control(dac_control), .slow_calib_value(slow_calib_value),
      .accel_calib_running(accel_calib_running),
      .fod_in_reset(fod_in_reset), .cfg_word(cfg_word),
      .auto_check_req(auto_check_req), .cfg_index(cfg_index),
      .check_busy(check_busy), .irq(irq)
   );

   //////////////////////////////////////////////////////////////////////
   // Reference models
   function automatic logic [31:0] crc_ref();
      logic [31:0] c;
      logic [31:0] w;
      c = calib_crc_pkg::CRC_INIT;
      for (int i = 0; i < calib_crc_pkg::CFG_WORDS; i++)
      begin
         w = cfg_at(4'(i));
         for (int b = 0; b < 32; b++)
            c = (c >> 1) ^ ((c[0] ^ w[b]) ? calib_crc_pkg::CRC_POLY : 0);
      end
      return c ^ calib_crc_pkg::CRC_XOR;
   endfunction

   function automatic logic [31:0] cal_mux(input logic [1:0] s);
      case (s)
         2'h0: return {ring_osc_state_count, lpf_value};
         2'h1: return {11'h0, ring_osc_phase[20:15], ring_osc_phase[14:0]};
         2'h2: return {ring_osc_captured, 7'h0, dac_control};
         default: return {ring_osc_analog, slow_calib_value};
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic edge_rdy();
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 64);
      if (k >= 64)
      begin
         num_errors++;
         $display("ERROR at %0t: bus wait timed out", $time);
         end_sim();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      edge_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rdv);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, rdv);
      chk(rdv, e);
   endtask

   task automatic rdcal(input logic [1:0] s);
      logic [31:0] nxt;
      nxt = cal_mux(s);
      bus(1'b0, calib_crc_pkg::OFF_CALIB_STS, 32'h0, rdv);
      chk(rdv, snap);
      snap = nxt;
   endtask

   task automatic set_in(input logic [3:0] k);
      ring_osc_state_count <= {k, 13'h1A5C};
      ring_osc_phase       <= {k, 17'h1B3D7};
      ring_osc_captured    <= {13'h0F0F, k};
      ring_osc_analog      <= {k, 13'h0C3A};
      lpf_value            <= {1'b1, k, 10'h2E7};
      dac_control          <= {k, 4'h9};
      slow_calib_value     <= {k, 11'h5D3};
      @(posedge hclk);
   endtask

   task automatic wait_done();
      int k;
      k = 0;
      do
      begin
         bus(1'b0, calib_crc_pkg::OFF_EVENT, 32'h0, rdv);
         if (rdv[2] !== 1'b1)
            chk(rdv, 32'h0);
         k++;
      end
      while (rdv[2] !== 1'b1 && k < 40);
      if (k >= 40)
      begin
         num_errors++;
         $display("ERROR at %0t: check never finished", $time);
         end_sim();
      end
   endtask

   //////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      logic [7:0] a [7] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
                            8'h1C};
      foreach (a[i])
         rdc(a[i], 32'h0);
      rdcal(2'h0);
      chk({31'h0, irq}, 32'h0);
      $display("Test reset values done");
   endtask

   task automatic t_sig();
      wr(calib_crc_pkg::OFF_SIG_EXP, 32'hC0DE_4A21);
      rdc(calib_crc_pkg::OFF_SIG_EXP, 32'hC0DE_4A21);
      wr(calib_crc_pkg::OFF_SIG_CALC, 32'hFFFF_FFFF);
      rdc(calib_crc_pkg::OFF_SIG_CALC, 32'h0);
      wr(8'h24, 32'h1);
      rdc(8'h24, 32'h0);
      rdc(calib_crc_pkg::OFF_SIG_EXP, 32'hC0DE_4A21);
      $display("Test signature register done");
   endtask

   task automatic t_calib();
      for (int s = 0; s < 4; s++)
      begin
         wr(calib_crc_pkg::OFF_CONTROL, 32'(s));
         set_in(4'(2 * s + 1));
         rdcal(2'(s));
         set_in(4'(2 * s + 2));
         rdcal(2'(s));
      end
      $display("Test calibration status done");
   endtask

   task automatic t_fast();
      for (int i = 0; i < 3; i++)
      begin
         accel_calib_running <= (i != 2);
         fod_in_reset        <= (i == 1);
         repeat (2) @(posedge hclk);
         rdc(calib_crc_pkg::OFF_FAST_STS, {31'h0, i == 0});
      end
      $display("Test fast flag done");
   endtask

   task automatic t_check(input logic m, input logic [31:0] sig,
                          input logic [2:0] ev);
      wr(calib_crc_pkg::OFF_SIG_EXP, sig);
      wr(calib_crc_pkg::OFF_EVENT_MASK, 32'h3);
      wr(calib_crc_pkg::OFF_CONTROL, {28'h0, 1'b1, m, 2'h3});
      wait_done();
      rdc(calib_crc_pkg::OFF_SIG_CALC, crc_ref());
      rdc(calib_crc_pkg::OFF_EVENT, {29'h0, ev});
      rdc(calib_crc_pkg::OFF_CONTROL, {28'h0, 1'b0, m, 2'h3});
      chk({31'h0, irq}, {31'h0, ev[1:0] != 2'h0});
      wr(calib_crc_pkg::OFF_EVENT, 32'h7);
      rdc(calib_crc_pkg::OFF_EVENT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("Test signature check done");
   endtask

   task automatic t_auto();
      auto_check_req <= 1'b1;
      @(posedge hclk);
      auto_check_req <= 1'b0;
      repeat (8) @(posedge hclk);
      wr(calib_crc_pkg::OFF_CONTROL, 32'hB);
      wait_done();
      chk(rdv, 32'h4);
      wr(calib_crc_pkg::OFF_EVENT, 32'h7);
      repeat (30) @(posedge hclk);
      rdc(calib_crc_pkg::OFF_EVENT, 32'h0);
      $display("Test automatic check done");
   endtask

   //////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset();
      t_sig();
      t_calib();
      t_fast();
      t_check(1'b0, crc_ref() ^ 32'h1, 3'b101);
      t_check(1'b1, crc_ref() ^ 32'h1, 3'b110);
      t_check(1'b0, crc_ref(), 3'b100);
      t_auto();
      end_sim();
   end
endmodule
